// File: logic/dofc_top.sv
// Summary of operation
// (R1) Bit 6 of family register picks SONET or SDH rates for second output.
// (R2) Bit 5 of family register picks SONET or SDH rates for first output.
// (R3) Rate fields [7:6] and [5:4] pick the 1x/2x/4x/8x multiple of base rate.
// (R4) Differential register bits [1:0] pick off, PECL or LVDS; [7:2] unused.
// (R5) Unused bits read zero except reset-default ones, and ignore writes.
`timescale 1ns/1ns
`default_nettype none

module dofc_top
    import dofc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output var  dofc_out_cfg_t out_cfg
);

    // --------------------------------------------------------------------
    // Register state.
    // --------------------------------------------------------------------
    logic [7:0]  rate_reg,   rate_next;
    logic [7:0]  family_reg, family_next;
    logic [7:0]  diff_reg,   diff_next;
    logic        wr_pend_reg, wr_pend_next;
    logic [9:0]  wr_addr_reg, wr_addr_next;
    logic [31:0] hrdata_reg,  hrdata_next;
    dofc_out_cfg_t out_reg,   out_next;
    dofc_aux_cfg_t first_cfg, second_cfg;
    logic        access;
    logic        hreadyout_reg, hreadyout_next;
    logic        hresp_reg,     hresp_next;

    // --------------------------------------------------------------------
    // Helpers.
    // --------------------------------------------------------------------
    // Unused bits keep their reset value forever, so defaults like bit 3
    // of the family register read back while writes never reach them.
    function automatic logic [7:0] merge(input logic [7:0] old_val,
                                         input logic [7:0] new_val,
                                         input logic [7:0] wmask);
        merge = (old_val & ~wmask) | (new_val & wmask); // see (R5)
    endfunction

    function automatic logic [7:0] read_reg(input logic [9:0] addr,
                                            input logic [7:0] r,
                                            input logic [7:0] f,
                                            input logic [7:0] d);
        case (addr)
            RATE_SELECT_ADDR:   read_reg = r;
            FAMILY_SELECT_ADDR: read_reg = f;
            DIFF_STD_ADDR:      read_reg = d;
            default:            read_reg = 8'h00;
        endcase
    endfunction

    // Only the two documented standards switch the differential driver on.
    function automatic logic diff_drives(input logic [1:0] code);
        diff_drives = (code == DIFF_PECL) || (code == DIFF_LVDS); // see (R4)
    endfunction

    // --------------------------------------------------------------------
    // Bus address phase: zero wait states, always OKAY.
    // --------------------------------------------------------------------
    // Only haddr[9:0] is decoded, so the bank repeats every 1 KB of address
    // space; a system that needs a tighter window must qualify hsel.
    always_comb
    begin
        access       = hsel && hready && (htrans == HTRANS_NONSEQ);
        wr_pend_next = access && hwrite;
        wr_addr_next = access ? haddr[9:0] : wr_addr_reg;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 10'h000;
        end
        else
        begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
        end
    end

    // --------------------------------------------------------------------
    // Configuration registers.
    // --------------------------------------------------------------------
    // Write data arrives in the data phase, one cycle after the address,
    // which is why the address and the write flag are held in flops above.
    always_comb
    begin
        rate_next   = rate_reg;
        family_next = family_reg;
        diff_next   = diff_reg;
        if (wr_pend_reg)
        begin
            case (wr_addr_reg)
                RATE_SELECT_ADDR:   rate_next   = merge(rate_reg, hwdata[7:0], RATE_SELECT_WMASK);
                FAMILY_SELECT_ADDR: family_next = merge(family_reg, hwdata[7:0],
                                                        FAMILY_SELECT_WMASK);
                DIFF_STD_ADDR:      diff_next   = merge(diff_reg, hwdata[7:0], DIFF_STD_WMASK);
                default:            ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rate_reg   <= RATE_SELECT_RESET;
            family_reg <= FAMILY_SELECT_RESET;
            diff_reg   <= DIFF_STD_RESET;
        end
        else
        begin
            rate_reg   <= rate_next;
            family_reg <= family_next;
            diff_reg   <= diff_next;
        end
    end

    // --------------------------------------------------------------------
    // Read data.
    // --------------------------------------------------------------------
    // The read value is chosen from the next-state values, so a read in the
    // cycle right after a write already sees the freshly merged byte.
    always_comb
    begin
        hrdata_next = hrdata_reg;
        if (access && !hwrite)
            hrdata_next = {24'h000000, read_reg(haddr[9:0], rate_next, family_next, diff_next)};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_reg <= 32'h00000000;
        else
            hrdata_reg <= hrdata_next;
    end

    // --------------------------------------------------------------------
    // Transfer response.
    // --------------------------------------------------------------------
    // Ready and response never change, but they still leave flops so that
    // every bus output has the same clean, registered timing.
    always_comb
    begin
        hreadyout_next = 1'b1;
        hresp_next     = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
        else
        begin
            hreadyout_reg <= hreadyout_next;
            hresp_reg     <= hresp_next;
        end
    end

    // --------------------------------------------------------------------
    // Decoded output configuration.
    // --------------------------------------------------------------------
    // Code 3 of the standard field is reserved and keeps the driver off, so
    // a stray write can never leave the output in an undefined standard.
    dofc_rate_decode u_first
    (
        .family_sdh (family_reg[FIRST_FAMILY_BIT_POS]),           // see (R2)
        .rate_code  (rate_reg[FIRST_RATE_LSB +: 2]),              // see (R3)
        .cfg        (first_cfg)
    );

    dofc_rate_decode u_second
    (
        .family_sdh (family_reg[SECOND_FAMILY_BIT_POS]),          // see (R1)
        .rate_code  (rate_reg[SECOND_RATE_LSB +: 2]),             // see (R3)
        .cfg        (second_cfg)
    );

    always_comb
    begin
        out_next.first_aux   = first_cfg;
        out_next.second_aux  = second_cfg;
        out_next.diff_std    = dofc_diff_std_t'(diff_reg[DIFF_STD_LSB +: 2]); // see (R4)
        out_next.diff_enable = diff_drives(diff_reg[DIFF_STD_LSB +: 2]);
    end

    // --------------------------------------------------------------------
    // Output register.
    // --------------------------------------------------------------------
    // The decoded view trails the registers by one cycle; downstream logic
    // sees all zero, every driver off, while reset is held.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            out_reg <= '0;
        else
            out_reg <= out_next;
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp     = hresp_reg;
    assign out_cfg   = out_reg;

endmodule

`default_nettype wire

// File: logic/dofc_pkg.sv
`default_nettype none

package dofc_pkg;

    // --------------------------------------------------------------------
    // Register byte addresses.
    // --------------------------------------------------------------------
    // The printed offset 0x39 is not a multiple of four, so it is an index.
    localparam logic [7:0]  RATE_SELECT_IDX   = 8'h39;
    localparam logic [7:0]  FAMILY_SELECT_IDX = 8'h38;
    localparam logic [7:0]  DIFF_STD_IDX      = 8'h3A;
    localparam logic [9:0]  RATE_SELECT_ADDR   = {RATE_SELECT_IDX, 2'b00};
    localparam logic [9:0]  FAMILY_SELECT_ADDR = {FAMILY_SELECT_IDX, 2'b00};
    localparam logic [9:0]  DIFF_STD_ADDR      = {DIFF_STD_IDX, 2'b00};

    // --------------------------------------------------------------------
    // Reset values and writable masks.
    // --------------------------------------------------------------------
    localparam logic [7:0]  RATE_SELECT_RESET   = 8'h08;
    localparam logic [7:0]  FAMILY_SELECT_RESET = 8'h0D;
    localparam logic [7:0]  DIFF_STD_RESET      = 8'hC2;
    localparam logic [7:0]  RATE_SELECT_WMASK   = 8'hF0;
    localparam logic [7:0]  FAMILY_SELECT_WMASK = 8'h60;
    localparam logic [7:0]  DIFF_STD_WMASK      = 8'h03;

    // --------------------------------------------------------------------
    // Field positions.
    // --------------------------------------------------------------------
    localparam int SECOND_FAMILY_BIT_POS = 6;
    localparam int FIRST_FAMILY_BIT_POS  = 5;
    localparam int SECOND_RATE_LSB       = 6;
    localparam int FIRST_RATE_LSB        = 4;
    localparam int DIFF_STD_LSB          = 0;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0]
    {
        DIFF_OFF  = 2'h0,
        DIFF_PECL = 2'h1,
        DIFF_LVDS = 2'h2,
        DIFF_RSVD = 2'h3
    } dofc_diff_std_t;

    typedef struct packed
    {
        logic        family_sdh;
        logic [1:0]  rate_code;
        logic [14:0] freq_khz;
    } dofc_aux_cfg_t;

    typedef struct packed
    {
        dofc_aux_cfg_t  first_aux;
        dofc_aux_cfg_t  second_aux;
        dofc_diff_std_t diff_std;
        logic           diff_enable;
    } dofc_out_cfg_t;

endpackage

`default_nettype wire

// File: logic/dofc_rate_decode.sv
`timescale 1ns/1ns
`default_nettype none

module dofc_rate_decode
    import dofc_pkg::*;
(
    input  wire logic        family_sdh,
    input  wire logic [1:0]  rate_code,
    output var  dofc_aux_cfg_t cfg
);

    // Base rate 1544 or 2048 kHz, doubled per code step.
    always_comb
    begin
        cfg.family_sdh = family_sdh;
        cfg.rate_code  = rate_code;
        cfg.freq_khz   = (family_sdh ? 15'd2048 : 15'd1544) << rate_code; // see (R3)
    end

endmodule

`default_nettype wire

// File: bench/dofc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module dofc_checker
    import dofc_pkg::*;
(
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire logic          hsel,
    input wire logic [31:0]   haddr,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic          hready,
    input wire logic [31:0]   hrdata,
    input wire dofc_out_cfg_t out_cfg
);
    // ----------------------------------------------------------------
    // Decode and read-back checks.
    // ----------------------------------------------------------------
    // The outputs are zero in reset, so decode is judged from the second edge.
    logic up;
    wire  rd = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) up <= 1'b0;
        else up <= 1'b1;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Rates in kHz straight from the rate table, not from a shift.
    function automatic logic [14:0] khz(input logic sdh, input logic [1:0] code);
        case ({sdh, code})
            3'h0: khz = 15'h0608;
            3'h1: khz = 15'h0C10;
            3'h2: khz = 15'h1820;
            3'h3: khz = 15'h3040;
            3'h4: khz = 15'h0800;
            3'h5: khz = 15'h1000;
            3'h6: khz = 15'h2000;
            default: khz = 15'h4000;
        endcase
    endfunction
    property p_first;
        up |-> out_cfg.first_aux.freq_khz ==
            khz(out_cfg.first_aux.family_sdh, out_cfg.first_aux.rate_code);
    endproperty
    property p_second;
        up |-> out_cfg.second_aux.freq_khz ==
            khz(out_cfg.second_aux.family_sdh, out_cfg.second_aux.rate_code);
    endproperty
    property p_diff;
        up |-> out_cfg.diff_enable == (out_cfg.diff_std inside {DIFF_PECL, DIFF_LVDS});
    endproperty
    property p_fam_rd;
        rd && haddr[9:0] == FAMILY_SELECT_ADDR |=> (hrdata & 32'hFFFFFF9F) == 32'h0000000D;
    endproperty
    property p_rate_rd;
        rd && haddr[9:0] == RATE_SELECT_ADDR |=> (hrdata & 32'hFFFFFF0F) == 32'h00000008;
    endproperty
    property p_diff_rd;
        rd && haddr[9:0] == DIFF_STD_ADDR |=> (hrdata & 32'hFFFFFFFC) == 32'h000000C0;
    endproperty
    a_first: assert property (p_first)
        else $error("first aux rate wrong");
    a_second: assert property (p_second)
        else $error("second aux rate wrong");
    a_diff: assert property (p_diff)
        else $error("diff enable wrong");
    a_fam_rd: assert property (p_fam_rd)
        else $error("family fixed bits wrong");
    a_rate_rd: assert property (p_rate_rd)
        else $error("rate fixed bits wrong");
    a_diff_rd: assert property (p_diff_rd)
        else $error("diff fixed bits wrong");
    c_pecl: cover property (out_cfg.diff_std == DIFF_PECL);
    c_off: cover property (out_cfg.diff_std == DIFF_OFF);
    c_top: cover property (out_cfg.second_aux.freq_khz == 15'h4000);
endmodule
bind dofc_top dofc_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .out_cfg(out_cfg));
`default_nettype wire

// File: bench/tb_digital_output_freq_config.sv
`timescale 1ns/1ns
`default_nettype none
module tb_digital_output_freq_config
    import dofc_pkg::*;
;
    logic          hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pend = 0, hreadyout, hresp;
    logic [31:0]   haddr = 0, hwdata = 0, hrdata;
    logic [1:0]    htrans = 0;
    logic [2:0]    hsize = 0;
    dofc_out_cfg_t out_cfg;
    logic [9:0]    addr_tab [3] = '{FAMILY_SELECT_ADDR, RATE_SELECT_ADDR, DIFF_STD_ADDR};
    logic [7:0]    mask_tab [3] = '{FAMILY_SELECT_WMASK, RATE_SELECT_WMASK, DIFF_STD_WMASK};
    logic [7:0]    exp_tab  [3] = '{FAMILY_SELECT_RESET, RATE_SELECT_RESET, DIFF_STD_RESET};
    // Expected rates in kHz, indexed by {family bit, rate code}.
    logic [14:0]   khz_tab  [8] = '{15'h0608, 15'h0C10, 15'h1820, 15'h3040,
                                    15'h0800, 15'h1000, 15'h2000, 15'h4000};
    logic [31:0]   q [$];
    dofc_out_cfg_t oq [$];
    int            n_fail = 0, compares = 0;
    always #5 hclk = ~hclk;
    dofc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .out_cfg(out_cfg));
    // ----------------------------------------------------------------
    // Bus master.
    // ----------------------------------------------------------------
    task complete_run;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task wt;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50) n_fail++;
            if (n > 50) complete_run();
            @(posedge hclk);
        end
    endtask
    task xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsize <= 3'h2;
        wt();
        htrans <= 2'h0;
        // Upper data bits are random so that a stray use of them shows up.
        hwdata <= $urandom() & 32'hFFFFFF00 | {24'h0, d};
        wt();
    endtask
    task rd(input logic [9:0] a, input logic [7:0] e);
        q.push_back({24'h0, e});
        xfer(1'b0, a, 8'h00);
    endtask
    // Notes the decoded outputs that the expected registers imply; the
    // watcher compares them at the falling edge, where they are settled.
    task chk_out;
        dofc_out_cfg_t e;
        e.first_aux.family_sdh  = exp_tab[0][5];
        e.first_aux.rate_code   = exp_tab[1][5:4];
        e.first_aux.freq_khz    = khz_tab[{exp_tab[0][5], exp_tab[1][5:4]}];
        e.second_aux.family_sdh = exp_tab[0][6];
        e.second_aux.rate_code  = exp_tab[1][7:6];
        e.second_aux.freq_khz   = khz_tab[{exp_tab[0][6], exp_tab[1][7:6]}];
        e.diff_std              = dofc_diff_std_t'(exp_tab[2][1:0]);
        e.diff_enable           = exp_tab[2][1:0] inside {2'h1, 2'h2};
        oq.push_back(e);
        @(negedge hclk);
        @(posedge hclk);
    endtask
    always @(posedge hclk)
    begin
        if (pend)
        begin
            compares++;
            if (hrdata !== q[0])
            begin
                $display("mismatch t=%0t got %h exp %h", $time, hrdata, q[0]);
                n_fail++;
            end
            void'(q.pop_front());
            compares++;
            if (hresp !== 1'b0)
            begin
                $display("mismatch t=%0t got %h exp %h", $time, hresp, 1'b0);
                n_fail++;
            end
        end
        pend <= hsel && hreadyout && htrans == HTRANS_NONSEQ && !hwrite;
    end
    always @(negedge hclk)
    begin
        if (oq.size() > 0)
        begin
            compares++;
            if (out_cfg !== oq[0])
            begin
                $display("mismatch t=%0t got %h exp %h", $time, out_cfg, oq[0]);
                n_fail++;
            end
            void'(oq.pop_front());
        end
    end
    initial
    begin
        logic [7:0] d;
        int         k;
        void'($urandom(76672));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (k = 0; k < 3; k++) rd(addr_tab[k], exp_tab[k]);
        chk_out();
        $display("reset values done");
        for (int i = 0; i < 24; i++)
        begin
            k = i % 3;
            d = (i < 12) ? {4{2'(i / 3)}} : 8'($urandom());
            xfer(1'b1, addr_tab[k], d);
            exp_tab[k] = exp_tab[k] & ~mask_tab[k] | d & mask_tab[k];
            rd(addr_tab[k], exp_tab[k]);
            chk_out();
        end
        $display("write and read back done");
        xfer(1'b1, 10'h3FC, 8'hFF);
        rd(10'h3FC, 8'h00);
        for (k = 0; k < 3; k++) rd(addr_tab[k], exp_tab[k]);
        chk_out();
        $display("unmapped access done");
        // A reset in mid-run must bring every register back to its default.
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        exp_tab = '{FAMILY_SELECT_RESET, RATE_SELECT_RESET, DIFF_STD_RESET};
        for (k = 0; k < 3; k++) rd(addr_tab[k], exp_tab[k]);
        chk_out();
        $display("mid-run reset done");
        @(posedge hclk);
        complete_run();
    end
endmodule
`default_nettype wire
